//--- hw/adcst_cfg.svh
// Purpose: constants of the converter sequence and trigger control
// Assumes: one 10 MHz clock
// Notes: offsets are not used, control bits are plain ports
`ifndef ADCST_CFG_SVH
`define ADCST_CFG_SVH

// trigger polarity encodings
`define ADCST_POL_SW      3'h0
`define ADCST_POL_RISE    3'h1
`define ADCST_POL_FALL    3'h2
`define ADCST_POL_BOTH    3'h3
`define ADCST_POL_HIGH    3'h4
`define ADCST_POL_LOW     3'h5
`define ADCST_POL_TIMER   3'h6
`define ADCST_POL_PWM     3'h7

// trigger inputs: 8 selectable, then timer and pwm
`define ADCST_TRIG_NUM    8
`define ADCST_SRC_NUM     10
`define ADCST_SRC_TIMER   4'h8
`define ADCST_SRC_PWM     4'h9

// result and fifo shape
`define ADCST_RES_W       13
`define ADCST_SAR_W       12
`define ADCST_FIFO_DEPTH  8

// reset values
`define ADCST_POS_RST     3'h0
`define ADCST_SAR_RST     12'h000

`endif

//--- hw/adcst_fifo.sv
// Purpose: result fifo, show-ahead, head word held in a register
// Assumes: push only while wr_ready_out is high
// Notes: valid and ready on both sides
`timescale 1ns/1ps
`include "adcst_cfg.svh"

module adcst_fifo #(
    parameter int WIDTH = `ADCST_RES_W,
    parameter int DEPTH = `ADCST_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write side
    input wire logic wr_valid_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic wr_ready_out,
    // read side
    output logic rd_valid_out,
    output logic [WIDTH-1:0] rd_data_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, head_idx;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] head_q, head_d;
    logic valid_q, valid_d, full_q, full_d;
    logic push, pop;

    assign wr_ready_out = ~full_q;
    assign rd_valid_out = valid_q;
    assign rd_data_out = head_q;

    always_comb begin
        push = wr_valid_in & ~full_q;
        pop = rd_ready_in & valid_q;
        wr_ptr_d = push ? wr_ptr_q + AW'(1) : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        head_idx = rd_ptr_d;
        // bypass a word written into the head slot this cycle
        head_d = (push && wr_ptr_q == head_idx) ? wr_data_in : mem_q[head_idx];
        valid_d = cnt_d != '0;
        full_d = cnt_d == FULL_CNT;
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            head_q <= '0;
            valid_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
            head_q <= head_d;
            valid_q <= valid_d;
            full_q <= full_d;
        end
    end

endmodule : adcst_fifo

//--- hw/adcst_pkg.sv
// Purpose: types of the converter sequence and trigger control
// Assumes: nothing
// Notes: encodings live in adcst_cfg.svh
package adcst_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_WRITE
    } adcst_state_t;

endpackage : adcst_pkg

//--- hw/adcst_top.sv
// Purpose: sequence, trigger, stop and flag control of the converter unit
// Assumes: comparator answers within the cycle the trial word is shown
// Notes: control bits are plain ports; set and clear requests are pulses
//
// Summary of operation
// [R1] stop aborts the running conversion; its result never reaches the fifo
// [R2] stop resets the sequence position to the first channel
// [R3] after abort, stop and start bits clear; software waits for start low
// [R4] stop keeps every status flag and all fifo data
// [R5] polarity 000 software only, 001 rising, 010 falling, 011 both edges
// [R6] polarity 100 high level, 101 low level, 110 timer, 111 pwm
// [R7] hardware triggers count only while the start bit is set
// [R8] hardware triggers during a conversion are dropped, not queued
// [R9] software changes polarity only while start reads zero
// [R10] source field picks one of eight trigger inputs
// [R11] software changes source only while start reads zero
// [R12] discontinuous mode converts one channel per trigger
// [R13] otherwise one trigger converts the whole sequence; next restarts it, or continuous mode restarts it at once
// [R14] discontinuous last channel raises both done events, then wraps
// [R15] resolution 12, 10, 8 or 6 bits; fewer bits finish sooner
// [R16] results are 13 bits, unused low bits zero
// [R17] software changes resolution only while the converter is disabled
// [R18] conversion-done flag sets on each new result; enable gates interrupt
// [R19] conversion-done clears by a write of one or a fifo read
// [R20] sampling-done flag sets at end of sampling; write one clears
// [R21] sequence-done flag sets when the last result is in the fifo
// [R22] start converts at once in software mode, else at next trigger
// [R23] results go into a 13 bit by 8 entry fifo
// [R24] software never sets discontinuous and continuous together
// [R25] triggers pass two flip-flops; edges compare with previous sample
// [R26] stop while idle completes on the next clock
`timescale 1ns/1ps
`include "adcst_cfg.svh"

module adcst_top
    import adcst_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // software control
    input wire logic converter_enable_in,
    input wire logic start_set_in,
    input wire logic stop_set_in,
    input wire logic [2:0] trigger_polarity_sel_in,
    input wire logic [2:0] trigger_source_sel_in,
    input wire logic discontinuous_enable_in,
    input wire logic continuous_enable_in,
    input wire logic [1:0] conversion_resolution_in,
    input wire logic [2:0] sequence_last_in,
    input wire logic [3:0] sample_cycles_in,
    // interrupt enables and flag clears
    input wire logic conversion_done_irq_en_in,
    input wire logic sampling_done_irq_en_in,
    input wire logic sequence_done_irq_en_in,
    input wire logic conversion_done_clr_in,
    input wire logic sampling_done_clr_in,
    input wire logic sequence_done_clr_in,
    // trigger pins
    input wire logic [`ADCST_TRIG_NUM-1:0] trigger_input_in,
    input wire logic periodic_timer_in,
    input wire logic pwm_in,
    // analog core
    input wire logic core_cmp_in,
    output logic core_sample_out,
    output logic [`ADCST_SAR_W-1:0] core_dac_out,
    output logic [2:0] seq_pos_out,
    // status
    output logic start_request_out,
    output logic stop_request_out,
    output logic conversion_done_flag_out,
    output logic sampling_done_flag_out,
    output logic sequence_done_flag_out,
    output logic irq_out,
    // result stream
    output logic result_valid_out,
    output logic [`ADCST_RES_W-1:0] result_data_out,
    input wire logic result_ready_in
);

    ////////////////////////////////////////////////////////////////////////
    // reset release and trigger synchronisers

    logic rst_s1_q, rst_n;
    logic [`ADCST_SRC_NUM-1:0] src_raw, src_s1_q, src_s2_q, src_prev_q, rise, fall;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    assign src_raw = {pwm_in, periodic_timer_in, trigger_input_in};

    genvar gi;
    generate
        for (gi = 0; gi < `ADCST_SRC_NUM; gi++) begin : g_sync
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    src_s1_q[gi] <= 1'b0;
                    src_s2_q[gi] <= 1'b0;
                    src_prev_q[gi] <= 1'b0;
                end else begin
                    src_s1_q[gi] <= src_raw[gi]; // R25
                    src_s2_q[gi] <= src_s1_q[gi];
                    src_prev_q[gi] <= src_s2_q[gi];
                end
            end
            assign rise[gi] = src_s2_q[gi] & ~src_prev_q[gi]; // R25
            assign fall[gi] = ~src_s2_q[gi] & src_prev_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // trigger decode

    logic hw_trig;
    logic sel_now, sel_rise, sel_fall;

    always_comb begin
        sel_now = src_s2_q[trigger_source_sel_in]; // R10
        sel_rise = rise[trigger_source_sel_in];
        sel_fall = fall[trigger_source_sel_in];
        case (trigger_polarity_sel_in)
            `ADCST_POL_RISE: hw_trig = sel_rise; // R5
            `ADCST_POL_FALL: hw_trig = sel_fall; // R5
            `ADCST_POL_BOTH: hw_trig = sel_rise | sel_fall; // R5
            `ADCST_POL_HIGH: hw_trig = sel_now; // R6
            `ADCST_POL_LOW: hw_trig = ~sel_now; // R6
            `ADCST_POL_TIMER: hw_trig = rise[`ADCST_SRC_TIMER]; // R6
            `ADCST_POL_PWM: hw_trig = rise[`ADCST_SRC_PWM]; // R6
            default: hw_trig = 1'b0; // R5
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    adcst_state_t state_q, state_d;
    logic start_q, start_d, stop_q, stop_d, sw_go_q, sw_go_d;
    logic [2:0] pos_q, pos_d;
    logic [3:0] smp_cnt_q, smp_cnt_d, bit_q, bit_d, last_bit;
    logic [`ADCST_SAR_W-1:0] sar_q, sar_d, dac_q, dac_d, sar_new;
    logic sw_mode, go, last_pos, smp_end, sar_done, fifo_push, fifo_ready;
    logic sample_q, sample_d;

    always_comb begin
        sw_mode = trigger_polarity_sel_in == `ADCST_POL_SW;
        last_pos = pos_q == sequence_last_in;
        // hardware triggers only in idle with start set: never queued
        go = start_q && !stop_q && state_q == ST_IDLE
            && (sw_go_q || (!sw_mode && hw_trig)); // R7 R8 R22
        smp_end = smp_cnt_q == sample_cycles_in;
        // lowest trial bit: two fewer steps per resolution code
        last_bit = {1'b0, conversion_resolution_in, 1'b0}; // R15
        sar_new = core_cmp_in ? dac_q : sar_q;
        sar_done = bit_q == last_bit;
        fifo_push = state_q == ST_WRITE && fifo_ready && !stop_q; // R1
        state_d = state_q;
        start_d = start_q;
        stop_d = stop_q;
        sw_go_d = sw_go_q;
        pos_d = pos_q;
        smp_cnt_d = smp_cnt_q;
        bit_d = bit_q;
        sar_d = sar_q;
        dac_d = dac_q;
        if (stop_q) begin
            // abort drops the pending word and rewinds the sequence
            state_d = ST_IDLE; // R1
            pos_d = `ADCST_POS_RST; // R2
            stop_d = 1'b0; // R3 R26
            start_d = 1'b0; // R3
            sw_go_d = 1'b0;
        end else begin
            if (stop_set_in) begin
                stop_d = 1'b1;
            end else if (start_set_in && converter_enable_in && !start_q) begin
                start_d = 1'b1;
                sw_go_d = sw_mode; // R22
            end
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_d = ST_SAMPLE;
                        sw_go_d = 1'b0;
                        smp_cnt_d = 4'h0;
                    end
                end
                ST_SAMPLE: begin
                    smp_cnt_d = smp_cnt_q + 4'h1;
                    if (smp_end) begin
                        state_d = ST_CONVERT;
                        bit_d = 4'(`ADCST_SAR_W - 1);
                        sar_d = `ADCST_SAR_RST;
                        dac_d = 12'h800;
                    end
                end
                ST_CONVERT: begin
                    sar_d = sar_new;
                    if (sar_done) begin
                        state_d = ST_WRITE; // R15
                    end else begin
                        bit_d = bit_q - 4'h1;
                        dac_d = sar_new | (12'h001 << (bit_q - 4'h1));
                    end
                end
                ST_WRITE: begin
                    // a full fifo holds the result here and stalls the sequence
                    if (fifo_push) begin
                        pos_d = last_pos ? `ADCST_POS_RST : pos_q + 3'h1; // R14
                        smp_cnt_d = 4'h0;
                        if (discontinuous_enable_in) begin
                            state_d = ST_IDLE; // R12
                            start_d = !sw_mode;
                        end else if (!last_pos || continuous_enable_in) begin
                            state_d = ST_SAMPLE; // R13
                        end else begin
                            state_d = ST_IDLE; // R13
                            start_d = !sw_mode;
                        end
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
        sample_d = state_d == ST_SAMPLE;
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            sw_go_q <= 1'b0;
            pos_q <= `ADCST_POS_RST;
            smp_cnt_q <= 4'h0;
            bit_q <= 4'h0;
            sar_q <= `ADCST_SAR_RST;
            dac_q <= `ADCST_SAR_RST;
            sample_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            stop_q <= stop_d;
            sw_go_q <= sw_go_d;
            pos_q <= pos_d;
            smp_cnt_q <= smp_cnt_d;
            bit_q <= bit_d;
            sar_q <= sar_d;
            dac_q <= dac_d;
            sample_q <= sample_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags and interrupt

    logic eoc_q, eoc_d, sampling_done_flag_q, sampling_done_flag_d, eoseq_q, eoseq_d, irq_q, irq_d, rd_fire;

    always_comb begin
        rd_fire = result_ready_in & result_valid_out;
        // set wins over clear; stop clears none of these
        eoc_d = fifo_push | (eoc_q & ~conversion_done_clr_in & ~rd_fire); // R18 R19 R4
        sampling_done_flag_d = (state_q == ST_SAMPLE && smp_end && !stop_q)
            | (sampling_done_flag_q & ~sampling_done_clr_in); // R20
        eoseq_d = (fifo_push & last_pos) | (eoseq_q & ~sequence_done_clr_in); // R21 R14
        irq_d = (eoc_d & conversion_done_irq_en_in) | (sampling_done_flag_d & sampling_done_irq_en_in)
            | (eoseq_d & sequence_done_irq_en_in); // R18
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            eoc_q <= 1'b0;
            sampling_done_flag_q <= 1'b0;
            eoseq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            eoc_q <= eoc_d;
            sampling_done_flag_q <= sampling_done_flag_d;
            eoseq_q <= eoseq_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result fifo and outputs

    logic [`ADCST_RES_W-1:0] push_data;
    assign push_data = {1'b0, sar_q}; // R16

    adcst_fifo u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .wr_valid_in(fifo_push), // R23
        .wr_data_in(push_data),
        .wr_ready_out(fifo_ready),
        .rd_valid_out(result_valid_out),
        .rd_data_out(result_data_out),
        .rd_ready_in(result_ready_in)
    );

    assign core_sample_out = sample_q;
    assign core_dac_out = dac_q;
    assign seq_pos_out = pos_q;
    assign start_request_out = start_q;
    assign stop_request_out = stop_q;
    assign conversion_done_flag_out = eoc_q;
    assign sampling_done_flag_out = sampling_done_flag_q;
    assign sequence_done_flag_out = eoseq_q;
    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [3:0] conv_cyc_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            conv_cyc_q <= 4'h0;
        end else begin
            conv_cyc_q <= (state_q == ST_CONVERT) ? conv_cyc_q + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    AST_STOP_NO_PUSH: assert property (stop_q |-> !fifo_push) // R1
        else $error("result pushed during stop");
    AST_STOP_REWIND: assert property (stop_q |=> pos_q == 3'h0 && state_q == ST_IDLE) // R2
        else $error("sequence not rewound by stop");
    AST_STOP_CLEARS: assert property (stop_set_in && !stop_q |=> stop_q ##1 !stop_q && !start_q) // R3
        else $error("stop and start not cleared after abort");
    AST_STOP_KEEPS_FLAG: assert property (stop_q && eoc_q && !conversion_done_clr_in
        && !rd_fire |=> eoc_q) // R4
        else $error("stop cleared a flag");
    AST_NO_START_NO_TRIG: assert property (state_q == ST_IDLE && !start_q |=> state_q == ST_IDLE) // R7
        else $error("conversion began without start");
    AST_SW_AT_ONCE: assert property (start_set_in && !stop_set_in && converter_enable_in
        && sw_mode && !start_q && !stop_q && state_q == ST_IDLE
        ##1 !stop_set_in |=> state_q == ST_SAMPLE) // R22
        else $error("software start did not begin sampling");
    AST_RES_STEPS: assert property (state_q == ST_CONVERT && sar_done
        |-> conv_cyc_q == 4'(`ADCST_SAR_W - 1) - {conversion_resolution_in, 1'b0}) // R15
        else $error("wrong number of approximation steps");
    AST_LSB_ZERO: assert property (fifo_push && conversion_resolution_in == 2'h3
        |-> push_data[5:0] == 6'h00 && push_data[12] == 1'b0) // R16
        else $error("unused low bits not zero");
    AST_PUSH_EOC: assert property (fifo_push |=> eoc_q
        && (irq_q || !$past(conversion_done_irq_en_in))) // R18
        else $error("conversion done flag missing");
    AST_READ_CLEARS: assert property (eoc_q && rd_fire && !fifo_push |=> !eoc_q) // R19
        else $error("fifo read did not clear conversion done");
    AST_DISC_ONE: assert property (fifo_push && discontinuous_enable_in |=> state_q == ST_IDLE) // R12
        else $error("discontinuous mode ran past one channel");
    AST_LAST_WRAP: assert property (fifo_push && last_pos |=> eoseq_q && pos_q == 3'h0) // R14
        else $error("last channel did not wrap or flag sequence");
    AST_SMP_FLAG: assert property (state_q == ST_SAMPLE && smp_end && !stop_q |=> sampling_done_flag_q) // R20
        else $error("sampling done flag missing");

    COV_STOP_CONVERT: cover property (state_q == ST_CONVERT && stop_q);
    COV_DISC_WRAP: cover property (fifo_push && last_pos && discontinuous_enable_in);
    COV_FIFO_STALL: cover property (state_q == ST_WRITE && !fifo_ready);
    COV_HW_START: cover property (go && !sw_mode);

endmodule : adcst_top

//--- verification/adcst_core_model.sv
// Purpose: comparator of the analog core facing the converter control
// Assumes: the input level is held steady through each test
// Notes: answers in the same cycle that the trial word is shown
`timescale 1ns/1ps

module adcst_core_model (
    // analog level and trial word
    input wire logic [11:0] level_in,
    input wire logic [11:0] dac_in,
    // decision
    output logic cmp_out
);
    assign cmp_out = (level_in >= dac_in);
endmodule : adcst_core_model

//--- verification/adcst_top_bench.sv
// Purpose: self-checking bench of the converter sequence and trigger control
// Assumes: inputs change and checks run at the falling edge; popped results are sampled at the rising edge
// Notes: a queue of expected words is compared with every popped result
`timescale 1ns/1ps

module adcst_top_bench;
    logic clk_in = 1'b0, reset_n_in = 1'b0;
    logic en = 1'b0, st = 1'b0, sp = 1'b0, disc = 1'b0, continuous_enable = 1'b0, rdy = 1'b1;
    logic iec = 1'b0, ies = 1'b0, ieq = 1'b0, clc = 1'b0, cls = 1'b0, clq = 1'b0;
    logic tmr = 1'b0, pwm = 1'b0, cmp, smpo, sto, spo, fc, fs, fq, irq, vld;
    logic [2:0] pol = 3'h0, src = 3'h0, last = 3'h0, pos;
    logic [1:0] res = 2'h0;
    logic [3:0] smp = 4'h7;
    logic [7:0] trig = 8'h00;
    logic [11:0] lvl = 12'h000, dac;
    logic [12:0] data;
    logic [12:0] exp_q[$];
    int num_errors = 0, checks_done = 0, popped = 0, cyc = 0, base, lat, lat1;

    always #50 clk_in = ~clk_in;

    adcst_core_model adcst_core_model_inst (.level_in(lvl), .dac_in(dac), .cmp_out(cmp));

    adcst_top adcst_top_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .converter_enable_in(en),
        .start_set_in(st), .stop_set_in(sp), .trigger_polarity_sel_in(pol),
        .trigger_source_sel_in(src), .discontinuous_enable_in(disc),
        .continuous_enable_in(continuous_enable), .conversion_resolution_in(res),
        .sequence_last_in(last), .sample_cycles_in(smp), .conversion_done_irq_en_in(iec),
        .sampling_done_irq_en_in(ies), .sequence_done_irq_en_in(ieq),
        .conversion_done_clr_in(clc), .sampling_done_clr_in(cls), .sequence_done_clr_in(clq),
        .trigger_input_in(trig), .periodic_timer_in(tmr), .pwm_in(pwm), .core_cmp_in(cmp),
        .core_sample_out(smpo), .core_dac_out(dac), .seq_pos_out(pos),
        .start_request_out(sto), .stop_request_out(spo), .conversion_done_flag_out(fc),
        .sampling_done_flag_out(fs), .sequence_done_flag_out(fq), .irq_out(irq),
        .result_valid_out(vld), .result_data_out(data), .result_ready_in(rdy)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t ns: %s seen %0h expected %0h", $time, what, seen, want);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // low bits beyond the resolution read as zero
    function automatic logic [12:0] word_of(input logic [11:0] v, input logic [1:0] r);
        return {1'b0, v & (12'hfff << (2 * r))};
    endfunction : word_of

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick

    task automatic wait_pop(input int n);
        for (int i = 0; i < 3000 && popped < n; i++) tick(1);
        if (popped < n) begin
            check(popped, n, "result count at timeout");
            summarize();
        end
    endtask : wait_pop

    // one-cycle pulses: start, stop, clear conv, clear sampling, clear sequence
    task automatic strobe(input logic [4:0] k);
        {st, sp, clc, cls, clq} = k;
        tick(1);
        {st, sp, clc, cls, clq} = 5'h00;
    endtask : strobe

    task automatic fire(input int p, input logic act);
        case (p)
            2, 5: trig[src] = ~act;
            6: tmr = act;
            7: pwm = act;
            default: trig[src] = act;
        endcase
    endtask : fire

    always @(posedge clk_in) begin
        cyc++;
        if (vld === 1'b1 && rdy === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0, "unexpected word");
            else check(data, exp_q.pop_front(), "result word");
            popped++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd5f98f40));
        lvl = 12'($urandom);
        tick(3);
        check({vld, sto, spo, fc, fs, fq, irq, smpo}, 8'h00, "outputs in reset");
        reset_n_in = 1'b1;
        tick(3);
        last = 3'h2;
        for (int r = 0; r < 4; r++) begin
            en = 1'b0;
            res = 2'(r);
            tick(1);
            en = 1'b1;
            tick(1);
            repeat (3) exp_q.push_back(word_of(lvl, res));
            base = popped;
            lat1 = cyc;
            strobe(5'h10);
            check(sto, 1, "start bit set");
            wait_pop(base + 1);
            lat1 = cyc - lat1;
            if (r > 0) check(lat1 + 2, lat, "resolution latency");
            lat = lat1;
            wait_pop(base + 3);
            tick(2);
            check({fq, sto, pos}, {1'b1, 1'b0, 3'h0}, "sequence end");
            strobe(5'h05);
        end
        $display("test software sequence done");
        disc = 1'b1;
        ieq = 1'b1;
        last = 3'h3;
        for (int i = 0; i < 6; i++) begin
            exp_q.push_back(word_of(lvl, res));
            base = popped;
            strobe(5'h10);
            wait_pop(base + 1);
            tick(2);
            check({fq, irq, sto, pos}, {i == 3, i == 3, 1'b0, 3'((i + 1) % 4)}, "step");
            strobe(5'h01);
        end
        $display("test discontinuous done");
        {disc, ieq, last} = 5'h00;
        for (int p = 1; p < 8; p++) begin
            pol = 3'(p);
            src = 3'($urandom);
            fire(p, 1'b0);
            tick(4);
            base = popped;
            fire(p, 1'b1);
            tick(6);
            check(smpo, 0, "trigger while start low");
            fire(p, 1'b0);
            tick(6);
            check(popped, base, "trigger while start low");
            strobe(5'h10);
            repeat (4) begin
                trig = trig ^ (p > 5 ? 8'hff : ~(8'h01 << src));
                tick(2);
                check(smpo, 0, "unselected trigger");
            end
            tick(4);
            check({popped == base, smpo}, 2'b10, "unselected trigger");
            repeat (4) exp_q.push_back(word_of(lvl, res));
            fire(p, 1'b1);
            if (p == 3) begin
                tick(6);
                fire(p, 1'b0);
            end
            wait_pop(base + 1);
            fire(p, 1'b0);
            if (p == 3) begin
                tick(40);
                check(popped, base + 1, "trigger during conversion");
            end
            strobe(5'h08);
            tick(40);
            exp_q.delete();
            check({sto, spo}, 2'b00, "stop clears start");
        end
        $display("test hardware triggers done");
        {pol, last, iec, rdy} = 8'h0e;
        exp_q.push_back(word_of(lvl, res));
        base = popped;
        strobe(5'h10);
        tick(26);
        check({vld, fc, fs, irq}, 4'hf, "first word held");
        strobe(5'h08);
        tick(3);
        check({sto, spo, pos, fc, fs, vld}, {5'h00, 3'b111}, "stop keeps flags");
        iec = 1'b0;
        tick(2);
        check(irq, 0, "masked flag");
        iec = 1'b1;
        tick(30);
        rdy = 1'b1;
        wait_pop(base + 1);
        tick(30);
        check({popped == base + 1, fc, irq}, 3'b100, "aborted word dropped");
        strobe(5'h02);
        tick(2);
        check(fs, 0, "sampling flag cleared");
        strobe(5'h08);
        check(spo, 1, "stop bit set");
        tick(2);
        check({sto, spo}, 2'b00, "stop while idle");
        repeat (4) exp_q.push_back(word_of(lvl, res));
        base = popped;
        strobe(5'h10);
        wait_pop(base + 4);
        tick(40);
        check({popped == base + 4, sto, pos}, 5'b10000, "restart at first position");
        $display("test stop done");
        {continuous_enable, last, rdy} = 5'h12;
        base = popped;
        strobe(5'h10);
        tick(200);
        strobe(5'h08);
        tick(3);
        repeat (8) exp_q.push_back(word_of(lvl, res));
        for (int i = 0; i < 400 && vld === 1'b1; i++) begin
            rdy = 1'($urandom);
            tick(1);
        end
        rdy = 1'b1;
        tick(20);
        check(popped - base, 8, "fifo depth");
        $display("test fifo fill done");
        summarize();
    end
endmodule : adcst_top_bench
